/* common/chio_defines.svh */
// Constants for the channel host I/O register block.
`ifndef CHIO_DEFINES_SVH
`define CHIO_DEFINES_SVH
`define CHIO_OFS_CTRL 3'h0
`define CHIO_OFS_MATCH 3'h1
`define CHIO_OFS_BANK 3'h2
`define CHIO_OFS_WIN 3'h3
`define CHIO_OFS_LINE 3'h4
`define CHIO_OFS_LED 3'h5
`define CHIO_OFS_RSVD 3'h6
`define CHIO_OFS_ID 3'h7
`define CHIO_BIT_RUN 7
`define CHIO_BIT_SHARED_MEMORY_ENABLE 6
`define CHIO_BIT_HOST_INTERRUPT_ENABLE 5
`define CHIO_BIT_WDT 4
`define CHIO_BIT_HOST1 3
`define CHIO_BIT_HOST0 2
`define CHIO_BIT_CARD1 1
`define CHIO_BIT_CARD0 0
`define CHIO_RST_CTRL 8'h00
`define CHIO_RST_MATCH 8'h80
`define CHIO_RST_BANK 8'h00
`define CHIO_RST_WIN 8'h03
`define CHIO_RST_LINE 4'h0
`define CHIO_RSVD_VAL 8'h00
`define CHIO_MASK_MATCH 8'h7E
`define CHIO_MASK_BANK 8'h3E
`define CHIO_WIN_8K 8'h01
`define CHIO_WIN_16K 8'h03
`define CHIO_WIN_32K 8'h07
`define CHIO_WIN_64K 8'h0F
`define CHIO_WIN_128K 8'h1F
`define CHIO_WIN_256K 8'h3F
`define CHIO_LINE_2 4'h2
`define CHIO_LINE_5 4'h5
`define CHIO_LINE_7 4'h7
`define CHIO_LINE_9 4'h9
`define CHIO_LINE_10 4'hA
`define CHIO_LINE_11 4'hB
`define CHIO_LINE_12 4'hC
`define CHIO_IO_FIXED 2'h2
`define CHIO_ID_VAL 8'h5A
// Synchroniser reset image: the four strobe stages start at idle high.
`define CHIO_PIN_INIT 39'h00_000C_0003
`define CHIO_STROBE_IDLE 1'h1
`endif

/* common/chio_pkg.sv */
// Types shared by the channel host I/O register block.
package chio_pkg;
	typedef struct packed {
		logic iow_d;
		logic run;
		logic shared_memory_enable;
		logic host_interrupt_enable;
		logic wdt;
		logic [1:0] host_flag;
		logic [1:0] card_flag;
		logic [7:0] base_match;
		logic [7:0] bank;
		logic [7:0] win;
		logic [3:0] line_sel;
		logic [7:0] rd_data;
		logic rd_oe;
		logic [15:0] irq_drive;
		logic halt;
		logic health_red;
		logic health_green;
	} chio_state_s;
endpackage

/* common/chio_win_if.sv */
// Shared-memory window settings and decode results between modules.
`timescale 1ns/1ps
interface chio_win_if;
	logic enable;
	logic cycle;
	logic [7:0] base_match;
	logic [7:0] bank;
	logic [7:0] win_mask;
	logic [7:0] host_addr;
	logic select;
	logic [4:0] ram_addr;
	modport cfg (output enable, output cycle, output base_match,
		output bank, output win_mask, output host_addr,
		input select, input ram_addr);
	modport dec (input enable, input cycle, input base_match,
		input bank, input win_mask, input host_addr,
		output select, output ram_addr);
endinterface

/* logic/chio_memdec.sv */
// Shared-memory window decode and bank address build.
`timescale 1ns/1ps
module chio_memdec (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Window settings in, decode results out
	chio_win_if.dec win
);
	typedef struct packed {
		logic select;
		logic [4:0] ram_addr;
	} chio_memdec_s;
	chio_memdec_s st_reg;
	chio_memdec_s st_next;
	logic [7:0] diff;

	// Bits that the window mask marks are not compared; inside the window
	// the host address supplies them, above it the bank register does.
	always_comb
	begin
		diff = (win.host_addr ^ win.base_match) & ~win.win_mask;
		st_next.select = win.enable & win.cycle & (diff == 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			st_next.ram_addr[i] = win.win_mask[i + 1] ?
				win.host_addr[i + 1] : win.bank[i + 1];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign win.select = st_reg.select;
	assign win.ram_addr = st_reg.ram_addr;
endmodule

/* logic/chio_regs.sv */
// Per-channel host I/O register block of a network interface card.
// Function
// - Eight byte registers decoded at switch-set I/O base, offsets zero to seven.
// - Shared window at least 8K, defaulting to 16K after reset.
// - Interrupt logic of each channel is independent of other channels.
// - Control bit layout fixed; every control bit resets to zero.
// - Four doorbell flags, two toward processor, two toward host.
// - Host write of one sets processor flag and interrupts processor.
// - Processor flag reads one until its interrupt completes.
// - Selected host line driven high when enabled and a host flag set.
// - Processor sets host flags; they read one while pending.
// - Host write of one clears a host flag; zero does nothing.
// - Interrupt enable gates the line only; flags keep working.
// - Run bit low halts processor and forces health indicator red.
// - Run bit high without timeout lets processor run and own indicator.
// - Watchdog timeout while running halts processor and shows red.
// - Memory enable gates shared-memory response to host accesses.
// - Watchdog status sets on timeout or held reset, clears with run.
// - Four-bit line code selects host line 2,5,7,9,10,11 or 12.
// - Window size accepts only defined mask patterns; others ignored.
// - Base match supplies address bits 19 to 12, masked by window.
// - Bank register supplies shared RAM bits 17 to 13.
`timescale 1ns/1ps
`include "chio_defines.svh"
module chio_regs #(
	// Identification value; the default is arbitrary.
	parameter logic [7:0] ID_VALUE = `CHIO_ID_VAL
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Host I/O cycle pins
	input wire logic [10:0] io_addr_i,
	input wire logic io_rd_n_i,
	input wire logic io_wr_n_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Host memory cycle pins
	input wire logic [7:0] mem_addr_i,
	input wire logic mem_rd_n_i,
	input wire logic mem_wr_n_i,
	output logic mem_select_o,
	output logic [4:0] ram_addr_o,
	// Host interrupt lines, driven high only when enabled
	output logic [15:0] host_irq_o,
	output logic [15:0] host_irq_oe_o,
	// Base address switches and power sense pins
	input wire logic [5:0] base_switch_i,
	input wire logic power_indicator_red_i,
	input wire logic power_indicator_green_i,
	// Channel processor side
	input wire logic [1:0] host_doorbell_set_i,
	input wire logic [1:0] processor_doorbell_ack_i,
	input wire logic watchdog_expired_i,
	input wire logic processor_reset_held_i,
	input wire logic proc_health_red_i,
	input wire logic proc_health_green_i,
	input wire logic network_indicator_red_i,
	input wire logic network_indicator_green_i,
	output logic [1:0] processor_doorbell_o,
	output logic processor_halt_o,
	// Health indicator
	output logic health_indicator_red_o,
	output logic health_indicator_green_o
);
	localparam int PW = 39;
	chio_pkg::chio_state_s st_reg;
	chio_pkg::chio_state_s st_next;
	logic [PW-1:0] pin_sync;
	logic [10:0] s_addr;
	logic s_rd_n;
	logic s_wr_n;
	logic [7:0] s_data;
	logic [7:0] s_mem_addr;
	logic s_mem_rd_n;
	logic s_mem_wr_n;
	logic [5:0] s_switch;
	logic s_pwr_red;
	logic s_pwr_green;
	logic io_hit;
	logic wr_pulse;
	logic [2:0] ofs;
	logic [7:0] ctrl_view;
	logic [7:0] led_view;
	chio_win_if win ();

	// Only the three lowest address bits pick a register.
	function automatic logic hit_base(input logic [10:0] a,
		input logic [5:0] sw);
		hit_base = (a[10] == sw[5]) && (a[9:8] == `CHIO_IO_FIXED)
			&& (a[7:3] == sw[4:0]);
	endfunction

	function automatic logic win_valid(input logic [7:0] v);
		win_valid = (v == `CHIO_WIN_8K) || (v == `CHIO_WIN_16K)
			|| (v == `CHIO_WIN_32K) || (v == `CHIO_WIN_64K)
			|| (v == `CHIO_WIN_128K) || (v == `CHIO_WIN_256K);
	endfunction

	// Codes without a line leave every line undriven.
	function automatic logic [15:0] line_onehot(input logic [3:0] code);
		logic [15:0] r;
		r = 16'h0000;
		if ((code == `CHIO_LINE_2) || (code == `CHIO_LINE_5)
			|| (code == `CHIO_LINE_7) || (code == `CHIO_LINE_9)
			|| (code == `CHIO_LINE_10) || (code == `CHIO_LINE_11)
			|| (code == `CHIO_LINE_12))
		begin
			r[code] = 1'b1;
		end
		line_onehot = r;
	endfunction

	// Strobes reset to their idle level, so release makes no false edge.
	chio_sync #(
		.W(PW),
		.INIT(`CHIO_PIN_INIT)
	) u_pin_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.async_i({power_indicator_red_i, power_indicator_green_i,
			base_switch_i, io_addr_i, io_rd_n_i, io_wr_n_i, data_i,
			mem_addr_i, mem_rd_n_i, mem_wr_n_i}),
		.sync_o(pin_sync)
	);

	assign {s_pwr_red, s_pwr_green, s_switch, s_addr, s_rd_n, s_wr_n,
		s_data, s_mem_addr, s_mem_rd_n, s_mem_wr_n} = pin_sync;

	assign win.enable = st_reg.shared_memory_enable;
	assign win.cycle = ~s_mem_rd_n | ~s_mem_wr_n;
	assign win.base_match = st_reg.base_match;
	assign win.bank = st_reg.bank;
	assign win.win_mask = st_reg.win;
	assign win.host_addr = s_mem_addr;

	chio_memdec u_memdec (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.win(win.dec)
	);

	always_comb
	begin
		st_next = st_reg;
		io_hit = hit_base(s_addr, s_switch);
		ofs = s_addr[2:0];
		st_next.iow_d = s_wr_n;
		wr_pulse = io_hit & ~s_wr_n & st_reg.iow_d;

		// Doorbells toward the processor: host sets, processor clears.
		for (int i = 0; i < 2; i++)
		begin
			if (processor_doorbell_ack_i[i])
			begin
				st_next.card_flag[i] = 1'b0;
			end
			if (wr_pulse && (ofs == `CHIO_OFS_CTRL)
				&& s_data[`CHIO_BIT_CARD0 + i])
			begin
				st_next.card_flag[i] = 1'b1;
			end
		end

		// Doorbells toward the host: host clears, processor sets.
		for (int i = 0; i < 2; i++)
		begin
			if (wr_pulse && (ofs == `CHIO_OFS_CTRL)
				&& s_data[`CHIO_BIT_HOST0 + i])
			begin
				st_next.host_flag[i] = 1'b0;
			end
			if (host_doorbell_set_i[i])
			begin
				st_next.host_flag[i] = 1'b1;
			end
		end

		if (wr_pulse)
		begin
			if (ofs == `CHIO_OFS_CTRL)
			begin
				st_next.run = s_data[`CHIO_BIT_RUN];
				st_next.shared_memory_enable = s_data[`CHIO_BIT_SHARED_MEMORY_ENABLE];
				st_next.host_interrupt_enable = s_data[`CHIO_BIT_HOST_INTERRUPT_ENABLE];
			end
			else if (ofs == `CHIO_OFS_MATCH)
			begin
				st_next.base_match = (st_reg.base_match
					& ~`CHIO_MASK_MATCH)
					| (s_data & `CHIO_MASK_MATCH);
			end
			else if (ofs == `CHIO_OFS_BANK)
			begin
				st_next.bank = s_data & `CHIO_MASK_BANK;
			end
			else if (ofs == `CHIO_OFS_WIN)
			begin
				if (win_valid(s_data))
				begin
					st_next.win = s_data;
				end
			end
			else if (ofs == `CHIO_OFS_LINE)
			begin
				st_next.line_sel = s_data[3:0];
			end
		end

		// Timeout status holds until the run bit is seen low.
		if (!st_reg.run)
		begin
			st_next.wdt = 1'b0;
		end
		else if (watchdog_expired_i || processor_reset_held_i)
		begin
			st_next.wdt = 1'b1;
		end

		st_next.halt = ~st_next.run | st_next.wdt;
		if (st_next.halt)
		begin
			st_next.health_red = 1'b1;
			st_next.health_green = 1'b0;
		end
		else
		begin
			st_next.health_red = proc_health_red_i;
			st_next.health_green = proc_health_green_i;
		end

		// This channel drives only its own selected line.
		if (st_next.host_interrupt_enable && (st_next.host_flag != 2'b00))
		begin
			st_next.irq_drive = line_onehot(st_next.line_sel);
		end
		else
		begin
			st_next.irq_drive = 16'h0000;
		end

		ctrl_view = {st_reg.run, st_reg.shared_memory_enable, st_reg.host_interrupt_enable, st_reg.wdt,
			st_reg.host_flag, st_reg.card_flag};
		led_view = {2'b00, s_pwr_red, s_pwr_green, st_reg.health_red,
			st_reg.health_green, network_indicator_red_i,
			network_indicator_green_i};

		st_next.rd_oe = io_hit & ~s_rd_n;
		if (ofs == `CHIO_OFS_CTRL)
		begin
			st_next.rd_data = ctrl_view;
		end
		else if (ofs == `CHIO_OFS_MATCH)
		begin
			st_next.rd_data = st_reg.base_match;
		end
		else if (ofs == `CHIO_OFS_BANK)
		begin
			st_next.rd_data = st_reg.bank;
		end
		else if (ofs == `CHIO_OFS_WIN)
		begin
			st_next.rd_data = st_reg.win;
		end
		else if (ofs == `CHIO_OFS_LINE)
		begin
			st_next.rd_data = {4'h0, st_reg.line_sel};
		end
		else if (ofs == `CHIO_OFS_LED)
		begin
			st_next.rd_data = led_view;
		end
		else if (ofs == `CHIO_OFS_RSVD)
		begin
			st_next.rd_data = `CHIO_RSVD_VAL;
		end
		else
		begin
			st_next.rd_data = ID_VALUE;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= '0;
			st_reg.iow_d <= `CHIO_STROBE_IDLE;
			st_reg.halt <= 1'b1;
			st_reg.health_red <= 1'b1;
			st_reg.base_match <= `CHIO_RST_MATCH;
			st_reg.bank <= `CHIO_RST_BANK;
			st_reg.win <= `CHIO_RST_WIN;
			st_reg.line_sel <= `CHIO_RST_LINE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign data_o = st_reg.rd_data;
	assign data_oe_o = st_reg.rd_oe;
	assign mem_select_o = win.select;
	assign ram_addr_o = win.ram_addr;
	assign host_irq_o = st_reg.irq_drive;
	assign host_irq_oe_o = st_reg.irq_drive;
	assign processor_doorbell_o = st_reg.card_flag;
	assign processor_halt_o = st_reg.halt;
	assign health_indicator_red_o = st_reg.health_red;
	assign health_indicator_green_o = st_reg.health_green;
endmodule

/* logic/chio_sync.sv */
// Two-stage synchroniser for a bundle of pin inputs.
`timescale 1ns/1ps
module chio_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Pins in, synchronised out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
	} chio_sync_s;
	chio_sync_s st_reg;
	chio_sync_s st_next;

	always_comb
	begin
		st_next.q1 = async_i;
		st_next.q2 = st_reg.q1;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_reg <= {INIT, INIT};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.q2;
endmodule

/* verif/chio_host_model.sv */
// Host bus model issuing byte I/O cycles to one channel.
`timescale 1ns/1ps
module chio_host_model (
	// Clock and base switches
	input wire logic clk_i,
	input wire logic [5:0] sw_i,
	// Host I/O pins
	output logic [10:0] addr_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [7:0] dat_o,
	input wire logic [7:0] dat_i,
	input wire logic oe_i
);
	initial
	begin
		addr_o = 11'h000;
		rd_n_o = 1'h1;
		wr_n_o = 1'h1;
		dat_o = 8'h00;
	end
	// Strobe low six cycles, high at least four; data inverted when idle.
	task automatic cyc(input logic [2:0] a, input logic w,
		input logic [7:0] v, output logic [7:0] q);
		@(negedge clk_i);
		addr_o = {sw_i[5], 2'h2, sw_i[4:0], a};
		dat_o = w ? v : ~dat_o;
		rd_n_o = w;
		wr_n_o = !w;
		repeat (6) @(negedge clk_i);
		// A bus that nobody drives shows the inverse of the last value.
		q = oe_i ? dat_i : ~dat_i;
		rd_n_o = 1'h1;
		wr_n_o = 1'h1;
		dat_o = ~dat_o;
		repeat (3) @(negedge clk_i);
	endtask
endmodule

/* verif/chio_regs_asserts.sv */
// Checker for the channel host I/O register block.
`timescale 1ns/1ps
module chio_regs_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Observed pins
	input wire logic io_rd_n_i,
	input wire logic io_wr_n_i,
	input wire logic data_oe_o,
	input wire logic mem_rd_n_i,
	input wire logic mem_wr_n_i,
	input wire logic mem_select_o,
	input wire logic [15:0] host_irq_o,
	input wire logic [15:0] host_irq_oe_o,
	input wire logic watchdog_expired_i,
	input wire logic [1:0] processor_doorbell_ack_i,
	input wire logic [1:0] processor_doorbell_o,
	input wire logic processor_halt_o,
	input wire logic health_indicator_red_o,
	input wire logic health_indicator_green_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic mem_idle;
	assign mem_idle = mem_rd_n_i & mem_wr_n_i;
	a_irq_mirror: assert property (host_irq_o == host_irq_oe_o)
		else $error("irq drive and enable differ");
	a_irq_lines: assert property ((host_irq_o & ~16'h1EA4) == 16'h0000)
		else $error("irq on an unsupported line");
	a_irq_onehot: assert property ($onehot0(host_irq_o))
		else $error("more than one irq line driven");
	a_halt_red: assert property (processor_halt_o && $past(processor_halt_o)
		|-> health_indicator_red_o && !health_indicator_green_o)
		else $error("halted but health not red");
	a_wdt_halts: assert property (watchdog_expired_i && !processor_halt_o
		|-> ##[1:3] processor_halt_o)
		else $error("timeout did not halt");
	a_card_clear: assert property ((processor_doorbell_o
		| ($past(processor_doorbell_ack_i) & 2'h3)
		| ~$past(processor_doorbell_o)) == 2'h3)
		else $error("card flag cleared without ack");
	a_card_set: assert property (|(processor_doorbell_o
		& ~$past(processor_doorbell_o))
		|-> !($past(io_wr_n_i, 3) && $past(io_wr_n_i, 4)))
		else $error("card flag set without write");
	a_mem_strobe: assert property (mem_select_o
		|-> !($past(mem_idle, 3) && $past(mem_idle, 4)))
		else $error("memory select without strobe");
	a_oe_strobe: assert property (data_oe_o
		|-> !($past(io_rd_n_i, 3) && $past(io_rd_n_i, 4)))
		else $error("data driven without read");
	c_card: cover property (processor_doorbell_o != 2'h0);
	c_irq: cover property (host_irq_o != 16'h0000);
	c_mem: cover property (mem_select_o);
endmodule
bind chio_regs chio_regs_asserts i_chk (.*);

/* verif/chio_regs_tb.sv */
// Self-checking testbench for the channel host I/O register block.
`timescale 1ns/1ps
module chio_regs_tb;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value.
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [10:0] io_addr_i;
	logic io_rd_n_i, io_wr_n_i, data_oe_o, mem_select_o, processor_halt_o;
	logic [7:0] data_i, data_o, wm, rv [8], lv [8];
	logic [7:0] mem_addr_i = 8'h00;
	logic mem_rd_n_i = 1'h1, mem_wr_n_i = 1'h1, processor_reset_held_i = 1'h0;
	logic [5:0] base_switch_i = 6'h00;
	logic [1:0] pwr = 2'h0, net = 2'h0, ph = 2'h0;
	logic [4:0] pm = 5'h00;
	logic [4:0] ram_addr_o;
	logic [15:0] host_irq_o, host_irq_oe_o;
	logic [1:0] host_doorbell_set_i, processor_doorbell_ack_i;
	logic [1:0] processor_doorbell_o;
	logic watchdog_expired_i, health_indicator_red_o, health_indicator_green_o;
	logic power_indicator_red_i, power_indicator_green_i, proc_health_red_i;
	logic proc_health_green_i, network_indicator_red_i, network_indicator_green_i;
	int n_errors = 0;
	int checks = 0;
	assign {watchdog_expired_i, processor_doorbell_ack_i, host_doorbell_set_i} = pm;
	assign {power_indicator_red_i, power_indicator_green_i} = pwr;
	assign {network_indicator_red_i, network_indicator_green_i} = net;
	assign {proc_health_red_i, proc_health_green_i} = ph;
	chio_regs #(.ID_VALUE(ID)) i_dut (.*);
	chio_host_model i_host (.clk_i(clk_i), .sw_i(base_switch_i),
		.addr_o(io_addr_i), .rd_n_o(io_rd_n_i), .wr_n_o(io_wr_n_i),
		.dat_o(data_i), .dat_i(data_o), .oe_i(data_oe_o));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		logic [7:0] x;
		i_host.cyc(a, 1'h1, v, x);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] x;
		i_host.cyc(a, 1'h0, 8'h00, x);
		chk(16'(x), 16'(e));
	endtask
	// Processor-side pulse of one cycle: {timeout, ack[1:0], set[1:0]}.
	task automatic pls(input logic [4:0] m);
		@(negedge clk_i);
		pm = m;
		@(negedge clk_i);
		pm = 5'h00;
	endtask
	task automatic mcyc(input logic [7:0] a, input logic e);
		@(negedge clk_i);
		mem_addr_i = a;
		mem_rd_n_i = 1'h0;
		repeat (5) @(negedge clk_i);
		chk(16'(mem_select_o), 16'(e));
		if (e)
			chk(16'(ram_addr_o), {11'h000, 4'h1, a[1]});
		mem_rd_n_i = 1'h1;
		repeat (5) @(negedge clk_i);
	endtask
	initial
	begin
		#1000000;
		n_errors++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'h81d9));
		base_switch_i = 6'($urandom);
		pwr = 2'($urandom);
		net = 2'($urandom);
		ph = 2'($urandom);
		lv = '{8'h02, 8'h05, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h03};
		repeat (3) @(negedge clk_i);
		rstn_i = 1'h1;
		repeat (2) @(negedge clk_i);
		rv = '{8'h00, 8'h80, 8'h00, 8'h03, 8'h00, {2'h0, pwr, 2'h2, net}, 8'h00, ID};
		for (int i = 5; i < 8; i++)
			wr(3'(i), 8'hFF);
		for (int i = 0; i < 8; i++)
			rdc(3'(i), rv[i]);
		$display("test reset values done");
		wm = 8'h03;
		for (int i = 0; i < 12; i++)
		begin
			rv[0] = (i < 6) ? 8'((2 << i) - 1) : 8'($urandom);
			if (rv[0] inside {8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F})
				wm = rv[0];
			wr(3'h3, rv[0]);
			rdc(3'h3, wm);
		end
		for (int i = 0; i < 4; i++)
		begin
			rv[0] = 8'($urandom);
			wr(3'h1, rv[0]);
			wr(3'h2, rv[0]);
			wr(3'h4, rv[0]);
			rdc(3'h1, (rv[0] & 8'h7E) | 8'h80);
			rdc(3'h2, rv[0] & 8'h3E);
			rdc(3'h4, rv[0] & 8'h0F);
		end
		$display("test field masks done");
		wr(3'h1, 8'hD0);
		wr(3'h2, 8'h06);
		wr(3'h3, 8'h03);
		wr(3'h0, 8'h40);
		mcyc(8'hD0, 1'h1);
		mcyc(8'hD3, 1'h1);
		mcyc(8'hD4, 1'h0);
		wr(3'h0, 8'h00);
		mcyc(8'hD0, 1'h0);
		$display("test shared memory done");
		wr(3'h0, 8'h80);
		chk(16'(processor_halt_o), 16'h0000);
		chk(16'({health_indicator_red_o, health_indicator_green_o}), 16'(ph));
		pls(5'h10);
		repeat (3) @(negedge clk_i);
		chk(16'(processor_halt_o), 16'h0001);
		chk(16'({health_indicator_red_o, health_indicator_green_o}), 16'h2);
		rdc(3'h0, 8'h90);
		wr(3'h0, 8'h00);
		rdc(3'h0, 8'h00);
		repeat (500) @(negedge clk_i);
		wr(3'h0, 8'h80);
		chk(16'(processor_halt_o), 16'h0000);
		@(negedge clk_i);
		processor_reset_held_i = 1'h1;
		@(negedge clk_i);
		processor_reset_held_i = 1'h0;
		rdc(3'h0, 8'h90);
		chk(16'(processor_halt_o), 16'h0001);
		wr(3'h0, 8'h00);
		$display("test run and watchdog done");
		for (int j = 0; j < 2; j++)
		begin
			wr(3'h0, 8'(1 << j));
			chk(16'(processor_doorbell_o), 16'(1 << j));
			wr(3'h0, 8'h00);
			rdc(3'h0, 8'(1 << j));
			pls(5'(4 << j));
			rdc(3'h0, 8'h00);
		end
		for (int j = 0; j < 8; j++)
		begin
			wr(3'h4, lv[j]);
			pls(5'(1 << (j % 2)));
			rdc(3'h0, 8'(4 << (j % 2)));
			chk(host_irq_o, 16'h0000);
			wr(3'h0, 8'h20);
			chk(host_irq_o, (j < 7) ? 16'h0001 << lv[j] : 16'h0000);
			chk(host_irq_oe_o, (j < 7) ? 16'h0001 << lv[j] : 16'h0000);
			wr(3'h0, 8'(8'h20 | (4 << (j % 2))));
			rdc(3'h0, 8'h20);
			chk(host_irq_o, 16'h0000);
			wr(3'h0, 8'h00);
		end
		fork
			wr(3'h0, 8'h04);
			begin
				repeat (3) @(negedge clk_i);
				pm = 5'h01;
				@(negedge clk_i);
				pm = 5'h00;
			end
		join
		rdc(3'h0, 8'h04);
		wr(3'h0, 8'h04);
		rdc(3'h0, 8'h00);
		$display("test doorbells done");
		wr(3'h0, 8'h01);
		@(negedge clk_i);
		rstn_i = 1'h0;
		@(negedge clk_i);
		rstn_i = 1'h1;
		chk(16'(processor_doorbell_o), 16'h0000);
		rdc(3'h3, 8'h03);
		$display("test second reset done");
		conclude();
	end
endmodule
